// ===== standard_timer.sv
// standard timer: APB registers, counter, comparators and mode logic
`include "standard_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module standard_timer (
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic        i_external_clock_pin,
    input  wire logic        i_capture_input_pin,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_timer_out,
    output logic             o_timer_out_en,
    output logic             o_timer_irq
);
    // ********************************
    // reset release
    // ********************************
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    timer_core_if cif ();

    // ********************************
    // register bank
    // ********************************
    logic                   run_bit_q;
    logic                   run_prev_q;
    logic [`ST_PRESC_W-1:0] presc_sel_q;
    logic [`ST_PRESC_W-1:0] presc_cnt_q;
    logic [7:0]             ctrl1_q;
    logic [15:0]            cmp_a_q;
    logic [7:0]             period_q;
    logic                   match_a_flag_q;
    logic                   match_p_flag_q;
    logic                   cap_pend_q;
    logic                   tick_q;

    logic wr_en;
    logic rd_en;
    logic hit;
    assign wr_en = i_psel & i_penable & i_pwrite;
    assign rd_en = i_psel & i_penable & ~i_pwrite;
    always_comb begin
        case (i_paddr)
            `ST_CTRL0_OFFSET, `ST_CTRL1_OFFSET, `ST_COUNT_OFFSET,
            `ST_CMPA_OFFSET, `ST_PERIOD_OFFSET, `ST_FLAGS_OFFSET: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // prescaler: one timer tick every presc_sel+1 system clocks
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            presc_cnt_q <= '0;
            tick_q      <= 1'b0;
        end else if (presc_cnt_q >= presc_sel_q) begin
            presc_cnt_q <= '0;
            tick_q      <= 1'b1;
        end else begin
            presc_cnt_q <= presc_cnt_q + 1'b1;
            tick_q      <= 1'b0;
        end
    end

    // run bit: hardware set/clear sources win over software write
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            run_bit_q  <= 1'b0;
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run_bit_q;
            if (cif.ext_set_run) begin
                run_bit_q <= 1'b1;
            end else if (cif.auto_stop) begin
                run_bit_q <= 1'b0;
            end else if (wr_en && i_paddr == `ST_CTRL0_OFFSET) begin
                run_bit_q <= i_pwdata[`ST_RUN_BIT];
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            presc_sel_q <= `ST_PRESC_RESET;
            ctrl1_q     <= `ST_CTRL1_RESET;
            period_q    <= `ST_PERIOD_RESET;
        end else if (wr_en) begin
            if (i_paddr == `ST_CTRL0_OFFSET) begin
                presc_sel_q <= i_pwdata[`ST_PRESC_LO +: `ST_PRESC_W];
            end
            if (i_paddr == `ST_CTRL1_OFFSET) begin
                ctrl1_q <= i_pwdata[7:0];
            end
            if (i_paddr == `ST_PERIOD_OFFSET) begin
                period_q <= i_pwdata[7:0];
            end
        end
    end

    // compare A: capture has priority over a software write
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cmp_a_q <= `ST_CMPA_RESET;
        end else if (cif.capture) begin
            cmp_a_q <= cif.count;
        end else if (wr_en && i_paddr == `ST_CMPA_OFFSET) begin
            cmp_a_q <= i_pwdata[15:0];
        end
    end

    // flags: hardware set wins over write-one-to-clear
    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            match_a_flag_q <= 1'b0;
            match_p_flag_q <= 1'b0;
            cap_pend_q     <= 1'b0;
        end else begin
            cap_pend_q <= cif.capture;
            if (cif.match_a || cap_pend_q) begin
                match_a_flag_q <= 1'b1;
            end else if (wr_en && i_paddr == `ST_FLAGS_OFFSET
                         && i_pwdata[`ST_FLAG_A_BIT]) begin
                match_a_flag_q <= 1'b0;
            end
            if (cif.match_p) begin
                match_p_flag_q <= 1'b1;
            end else if (wr_en && i_paddr == `ST_FLAGS_OFFSET
                         && i_pwdata[`ST_FLAG_P_BIT]) begin
                match_p_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_prdata  <= 32'h00000000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~hit;
            o_prdata  <= 32'h00000000;
            if (i_psel && !i_penable && !i_pwrite) begin
                case (i_paddr)
                    `ST_CTRL0_OFFSET:  o_prdata <= {16'h0000, presc_sel_q, 7'h00, run_bit_q};
                    `ST_CTRL1_OFFSET:  o_prdata <= {24'h000000, ctrl1_q};
                    `ST_COUNT_OFFSET:  o_prdata <= {16'h0000, cif.count};
                    `ST_CMPA_OFFSET:   o_prdata <= {16'h0000, cmp_a_q};
                    `ST_PERIOD_OFFSET: o_prdata <= {24'h000000, period_q};
                    `ST_FLAGS_OFFSET:  o_prdata <= {30'h00000000, match_p_flag_q,
                                                    match_a_flag_q};
                    default:           o_prdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_timer_out    <= 1'b0;
            o_timer_out_en <= 1'b0;
            o_timer_irq    <= 1'b0;
        end else begin
            o_timer_out    <= cif.pin_level;
            o_timer_out_en <= cif.pin_en;
            o_timer_irq    <= match_a_flag_q | match_p_flag_q;
        end
    end

    assign cif.run       = run_bit_q;
    assign cif.run_rise  = run_bit_q & ~run_prev_q;
    assign cif.tick      = tick_q;
    assign cif.mode      = ctrl1_q[`ST_MODE_LO +: 2];
    assign cif.pin_code  = ctrl1_q[`ST_IO_LO +: 2];
    assign cif.level_ctl = ctrl1_q[`ST_OC_BIT];
    assign cif.invert    = ctrl1_q[`ST_POL_BIT];
    assign cif.swap      = ctrl1_q[`ST_DPX_BIT];
    assign cif.clear_sel = ctrl1_q[`ST_CCLR_BIT];
    assign cif.cmp_a     = cmp_a_q;
    assign cif.period    = period_q;

    // ********************************
    // counter and mode logic
    // ********************************
    logic clk_rise;
    logic cap_rise;
    logic cap_fall;
    timer_edge_sense u_edges (
        .i_clock    (i_clock),
        .i_rst_n    (rst_n_q),
        .i_clk_pin  (i_external_clock_pin),
        .i_cap_pin  (i_capture_input_pin),
        .o_clk_rise (clk_rise),
        .o_cap_rise (cap_rise),
        .o_cap_fall (cap_fall)
    );
    timer_core u_core (
        .i_clock    (i_clock),
        .i_rst_n    (rst_n_q),
        .i_clk_rise (clk_rise),
        .i_cap_rise (cap_rise),
        .i_cap_fall (cap_fall),
        .bus        (cif.core)
    );
endmodule
`default_nettype wire

// ===== standard_timer_regs.svh
// constants for the standard timer: register offsets, fields, reset values, prescaler width
`ifndef STANDARD_TIMER_REGS_SVH
`define STANDARD_TIMER_REGS_SVH

`define ST_CTRL0_OFFSET  12'h000
`define ST_CTRL1_OFFSET  12'h004
`define ST_COUNT_OFFSET  12'h008
`define ST_CMPA_OFFSET   12'h00C
`define ST_PERIOD_OFFSET 12'h010
`define ST_FLAGS_OFFSET  12'h014

// control one fields
`define ST_CCLR_BIT  0
`define ST_DPX_BIT   1
`define ST_POL_BIT   2
`define ST_OC_BIT    3
`define ST_IO_LO     4
`define ST_MODE_LO   6
// control zero fields
`define ST_RUN_BIT   0
`define ST_PRESC_LO  8
// flag register fields
`define ST_FLAG_A_BIT 0
`define ST_FLAG_P_BIT 1

`define ST_CTRL1_RESET  8'h00
`define ST_PRESC_RESET  8'h00
`define ST_CMPA_RESET   16'h0000
`define ST_PERIOD_RESET 8'h00

`define ST_PRESC_W 8
`endif

// ===== standard_timer_pkg.sv
// types shared by the standard timer modules
package standard_timer_pkg;
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_PWM     = 2'b10,
        MODE_TIMER   = 2'b11
    } mode_e;
    typedef enum logic [1:0] {
        PIN_CODE_00 = 2'b00,
        PIN_CODE_01 = 2'b01,
        PIN_CODE_10 = 2'b10,
        PIN_CODE_11 = 2'b11
    } pin_code_e;
endpackage

// ===== timer_core_if.sv
// signals between the register side and the timer core
`timescale 1ns/1ps
`default_nettype none
interface timer_core_if;
    logic        run;
    logic        run_rise;
    logic        tick;
    logic [1:0]  mode;
    logic [1:0]  pin_code;
    logic        level_ctl;
    logic        invert;
    logic        swap;
    logic        clear_sel;
    logic [15:0] cmp_a;
    logic [7:0]  period;
    logic        ext_set_run;
    logic        match_a;
    logic        match_p;
    logic        capture;
    logic        auto_stop;
    logic [15:0] count;
    logic        pin_level;
    logic        pin_en;
    modport regs (output run, run_rise, tick, mode, pin_code, level_ctl, invert, swap,
                  clear_sel, cmp_a, period,
                  input ext_set_run, match_a, match_p, capture, auto_stop, count,
                  pin_level, pin_en);
    modport core (input run, run_rise, tick, mode, pin_code, level_ctl, invert, swap,
                  clear_sel, cmp_a, period,
                  output ext_set_run, match_a, match_p, capture, auto_stop, count,
                  pin_level, pin_en);
endinterface
`default_nettype wire

// ===== timer_edge_sense.sv
// edge sensing on the external clock and capture pins
`timescale 1ns/1ps
`default_nettype none
module timer_edge_sense (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_clk_pin,
    input  wire logic i_cap_pin,
    output logic      o_clk_rise,
    output logic      o_cap_rise,
    output logic      o_cap_fall
);
    logic clk_pin_q;
    logic cap_pin_q;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_pin_q <= 1'b0;
            cap_pin_q <= 1'b0;
        end else begin
            clk_pin_q <= i_clk_pin;
            cap_pin_q <= i_cap_pin;
        end
    end

    assign o_clk_rise = i_clk_pin & ~clk_pin_q;
    assign o_cap_rise = i_cap_pin & ~cap_pin_q;
    assign o_cap_fall = ~i_cap_pin & cap_pin_q;
endmodule
`default_nettype wire

// ===== timer_core.sv
// counter, comparators and per-mode output behaviour
`include "standard_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module timer_core (
    input  wire logic  i_clock,
    input  wire logic  i_rst_n,
    input  wire logic  i_clk_rise,
    input  wire logic  i_cap_rise,
    input  wire logic  i_cap_fall,
    timer_core_if.core bus
);
    logic [15:0] count_q;
    logic        out_q;
    logic        single;
    logic        pwm;
    logic        cmp_like;
    logic        hit_a;
    logic        hit_p;
    logic        edge_ok;
    logic        duty_on;

    assign single   = bus.mode == standard_timer_pkg::MODE_PWM
                      && bus.pin_code == standard_timer_pkg::PIN_CODE_11;
    assign pwm      = bus.mode == standard_timer_pkg::MODE_PWM && !single;
    assign cmp_like = bus.mode == standard_timer_pkg::MODE_COMPARE
                      || bus.mode == standard_timer_pkg::MODE_TIMER;
    // period compare on the top byte only; the match sits on the last count so a
    // period value spans value x 256 ticks; zero means full overflow
    // no match in the restart cycle: the count there is stale until it is zeroed
    assign hit_a = bus.run && bus.tick && !bus.run_rise && count_q == bus.cmp_a;
    assign hit_p = bus.run && bus.tick && !bus.run_rise
                   && (bus.period == 8'h00 ? count_q == 16'hFFFF
                       : count_q == {bus.period - 8'h01, 8'hFF});

    always_comb begin
        case (bus.pin_code)
            standard_timer_pkg::PIN_CODE_00: edge_ok = i_cap_rise;
            standard_timer_pkg::PIN_CODE_01: edge_ok = i_cap_fall;
            standard_timer_pkg::PIN_CODE_10: edge_ok = i_cap_rise | i_cap_fall;
            default:                         edge_ok = 1'b0;
        endcase
    end

    // duty: first part of the period is active; duty >= period gives full on, duty > period when swapped
    always_comb begin
        if (!bus.swap) begin
            duty_on = count_q < bus.cmp_a;
            if (bus.period != 8'h00 && bus.cmp_a >= {bus.period, 8'h00}) begin
                duty_on = 1'b1;
            end
        end else begin
            duty_on = (bus.period == 8'h00) ? 1'b1 : count_q < {bus.period, 8'h00};
            if (bus.period != 8'h00 && {bus.period, 8'h00} > bus.cmp_a) begin
                duty_on = 1'b1;
            end
        end
    end

    assign bus.capture     = bus.mode == standard_timer_pkg::MODE_CAPTURE
                             && bus.run && edge_ok;
    assign bus.ext_set_run = single && !bus.run && i_clk_rise;
    assign bus.auto_stop   = single && hit_a;
    assign bus.count       = count_q;

    always_comb begin
        bus.match_a = 1'b0;
        bus.match_p = 1'b0;
        if (cmp_like) begin
            bus.match_a = hit_a && bus.cmp_a != 16'h0000;
            bus.match_p = hit_p && !bus.clear_sel;
        end else if (pwm) begin
            bus.match_a = hit_a;
            bus.match_p = hit_p;
        end else if (single) begin
            bus.match_a = hit_a;
        end else begin
            bus.match_p = hit_p;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= 16'h0000;
        end else if (bus.run_rise) begin
            count_q <= 16'h0000;
        end else if (bus.run && bus.tick) begin
            if (single) begin
                count_q <= count_q + 16'h0001;
            end else if (pwm ? (bus.swap ? hit_a : hit_p) :
                         cmp_like ? (bus.clear_sel ? bus.match_a : hit_p) : hit_p) begin
                count_q <= 16'h0000;
            end else begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_q <= 1'b0;
        end else if (bus.run_rise) begin
            out_q <= bus.level_ctl;
        end else if (cmp_like && bus.match_a) begin
            case (bus.pin_code)
                standard_timer_pkg::PIN_CODE_01: out_q <= 1'b0;
                standard_timer_pkg::PIN_CODE_10: out_q <= 1'b1;
                standard_timer_pkg::PIN_CODE_11: out_q <= ~out_q;
                default:                         out_q <= out_q;
            endcase
        end else if (single && !bus.run) begin
            out_q <= ~bus.level_ctl;
        end
    end

    always_comb begin
        bus.pin_en    = 1'b1;
        bus.pin_level = out_q ^ bus.invert;
        if (bus.mode == standard_timer_pkg::MODE_TIMER
            || bus.mode == standard_timer_pkg::MODE_CAPTURE) begin
            bus.pin_en    = 1'b0;
            bus.pin_level = 1'b0;
        end else if (pwm) begin
            case (bus.pin_code)
                standard_timer_pkg::PIN_CODE_00: bus.pin_level = ~bus.level_ctl ^ bus.invert;
                standard_timer_pkg::PIN_CODE_01: bus.pin_level = bus.level_ctl ^ bus.invert;
                default: bus.pin_level = (duty_on ? bus.level_ctl : ~bus.level_ctl)
                                         ^ bus.invert;
            endcase
        end else if (single) begin
            bus.pin_level = (bus.run ? bus.level_ctl : ~bus.level_ctl) ^ bus.invert;
        end
    end
endmodule
`default_nettype wire

// ===== standard_timer_chk.sv
// port-level concurrent checks for the standard timer
`include "standard_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module standard_timer_chk (
    input wire logic        i_clock,
    input wire logic        i_resetn,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_timer_out,
    input wire logic        o_timer_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    logic mapped;
    assign mapped = i_paddr inside {`ST_CTRL0_OFFSET, `ST_CTRL1_OFFSET, `ST_COUNT_OFFSET,
                                    `ST_CMPA_OFFSET, `ST_PERIOD_OFFSET, `ST_FLAGS_OFFSET};
    a_ready_next: assert property (i_psel && !i_penable |=> o_pready)
        else $error("ready missing after setup");
    a_ready_cause: assert property (o_pready |-> i_psel && i_penable && $past(!i_penable))
        else $error("ready outside an access phase");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_err_cause: assert property (o_pslverr |-> o_pready && !mapped)
        else $error("error without unmapped access");
    a_err_unmapped: assert property (i_psel && !i_penable && !mapped |=> o_pslverr)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (i_psel && !i_penable && mapped |=> !o_pslverr)
        else $error("mapped access refused");
    a_err_read_zero: assert property (o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("refused read returned data");
    a_reset_quiet: assert property ($rose(i_resetn) |-> !o_timer_out && !o_timer_irq && !o_pready)
        else $error("outputs active at reset release");
endmodule
bind standard_timer standard_timer_chk u_standard_timer_chk (.i_clock(i_clock),
    .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_timer_out(o_timer_out), .o_timer_irq(o_timer_irq));
`default_nettype wire

// ===== timer_pin_model.sv
// model of the trigger and capture sources on the timer's input pins
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
    input  wire logic       i_clock,
    input  wire logic       i_cap_level,
    input  wire logic       i_fire,
    input  wire logic [3:0] i_delay,
    output logic            o_external_clock_pin,
    output logic            o_capture_input_pin
);
    logic [4:0] pend_q = 5'h00;
    logic [3:0] wait_q = 4'h0;
    initial o_capture_input_pin = 1'b0;
    // trigger pulse held three clocks so a slow sampler still sees it
    always_ff @(posedge i_clock) begin
        if (i_fire && pend_q == 5'h00) begin
            pend_q <= {1'b0, i_delay} + 5'h04;
        end else if (pend_q != 5'h00) begin
            pend_q <= pend_q - 5'h01;
        end
    end
    assign o_external_clock_pin = (pend_q != 5'h00) && (pend_q <= 5'h03);
    // capture level follows the request after the chosen latency
    always_ff @(posedge i_clock) begin
        if (i_cap_level == o_capture_input_pin) begin
            wait_q <= 4'h0;
        end else if (wait_q >= i_delay) begin
            o_capture_input_pin <= i_cap_level;
            wait_q              <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the standard timer
`include "standard_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_clock = 1'b0;
    logic        i_resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rdat, a_sv;
    logic        pready, pslverr, tout, ten, irq, ext, cap, rerr;
    logic        cap_lvl = 1'b0;
    logic        fire = 1'b0;
    logic [3:0]  dly = 4'h0;
    int          fails = 0;
    int          tests_run = 0;
    int          hcnt;
    logic [11:0] offs [6] = '{`ST_CTRL0_OFFSET, `ST_CTRL1_OFFSET, `ST_COUNT_OFFSET,
                              `ST_CMPA_OFFSET, `ST_PERIOD_OFFSET, `ST_FLAGS_OFFSET};
    logic [1:0]  pw_pin [6] = '{2'b10, 2'b10, 2'b10, 2'b10, 2'b00, 2'b01};
    logic        pw_inv [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic        pw_swp [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [15:0] pw_a   [6] = '{16'h0040, 16'h0040, 16'h0200, 16'h0200, 16'h0040, 16'h0040};
    int          pw_win [6] = '{256, 256, 256, 513, 256, 256};
    int          pw_exp [6] = '{64, 192, 256, 256, 0, 256};
    logic        cap_r  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic        cap_f  [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    always #12.5 i_clock = ~i_clock;
    standard_timer u_standard_timer (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_external_clock_pin(ext), .i_capture_input_pin(cap), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_timer_out(tout), .o_timer_out_en(ten),
        .o_timer_irq(irq));
    timer_pin_model u_timer_pin_model (.i_clock(i_clock), .i_cap_level(cap_lvl),
        .i_fire(fire), .i_delay(dly), .o_external_clock_pin(ext), .o_capture_input_pin(cap));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", s, e, g);
            fails++;
        end
    endtask
    // ready, data and error are read as they stood just before the sampling edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1 && n < 40) begin
            n++;
            @(posedge i_clock);
        end
        if (n == 40) begin
            check("apb_ready", 1, 0);
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic hi(input int n);
        hcnt = 0;
        repeat (n) begin
            @(negedge i_clock);
            if (tout === 1'b1) hcnt++;
        end
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] p,
                                        input logic l, input logic i, input logic s,
                                        input logic c);
        return {24'h000000, m, p, l, i, s, c};
    endfunction
    // the mode is always changed with the counter stopped
    task automatic start(input logic [31:0] c1, input logic [15:0] a, input logic [7:0] per,
                         input logic go);
        apb(1'b1, `ST_CTRL0_OFFSET, 32'h00000000);
        apb(1'b1, `ST_CMPA_OFFSET, {16'h0000, a});
        apb(1'b1, `ST_PERIOD_OFFSET, {24'h000000, per});
        apb(1'b1, `ST_CTRL1_OFFSET, c1);
        apb(1'b1, `ST_FLAGS_OFFSET, 32'h00000003);
        apb(1'b1, `ST_CTRL0_OFFSET, {31'h00000000, go});
    endtask
    initial begin
        repeat (40000) @(posedge i_clock);
        fails++;
        report_and_stop();
    end
    initial begin
        int n;
        repeat (10) @(posedge i_clock);
        i_resetn <= 1'b1;
        cyc(4);
        foreach (offs[k]) begin
            apb(1'b0, offs[k], 32'h00000000);
            check("reset_value", 32'h00000000, rdat);
        end
        apb(1'b1, 12'h018, 32'hFFFFFFFF);
        check("unmapped_err", 1, rerr);
        apb(1'b0, 12'h018, 32'h00000000);
        check("unmapped_data", 32'h00000000, rdat);
        start(ctl(2'b00, 2'b10, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0200, 8'h01, 1'b1);
        cyc(1200);
        apb(1'b0, `ST_FLAGS_OFFSET, 32'h00000000);
        check("cmp_flags", 32'h00000001, rdat);
        apb(1'b0, `ST_COUNT_OFFSET, 32'h00000000);
        check("cmp_count_ok", 1, 32'(rdat <= 32'h00000200));
        check("cmp_out_set", 1, tout);
        check("cmp_out_en", 1, ten);
        apb(1'b1, `ST_CTRL0_OFFSET, 32'h00000000);
        apb(1'b1, `ST_CTRL0_OFFSET, 32'h00000001);
        cyc(3);
        check("cmp_out_init", 0, tout);
        start(ctl(2'b11, 2'b00, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0200, 8'h01, 1'b1);
        cyc(1200);
        check("tmr_out_en", 0, ten);
        apb(1'b0, `ST_FLAGS_OFFSET, 32'h00000000);
        check("tmr_flags", 32'h00000001, rdat);
        for (int r = 0; r < 6; r++) begin
            start(ctl(2'b10, pw_pin[r], 1'b1, pw_inv[r], pw_swp[r], 1'b1), pw_a[r], 8'h01, 1'b1);
            cyc(700);
            hi(pw_win[r]);
            check("pwm_high", pw_exp[r], hcnt);
            if (r == 0 || r == 4) begin
                apb(1'b0, `ST_FLAGS_OFFSET, 32'h00000000);
                check("pwm_flags", 32'h00000003, rdat);
            end
        end
        start(ctl(2'b10, 2'b11, 1'b1, 1'b0, 1'b1, 1'b1), 16'h0020, 8'h01, 1'b0);
        dly <= 4'h5;
        fire <= 1'b1;
        @(posedge i_clock);
        fire <= 1'b0;
        n = 0;
        while (tout !== 1'b1 && n < 60) begin
            @(negedge i_clock);
            n++;
        end
        check("sp_start", 1, tout);
        hcnt = 0;
        while (tout === 1'b1 && hcnt < 100) begin
            @(negedge i_clock);
            hcnt++;
        end
        check("sp_width_ok", 1, 32'(hcnt >= 33 && hcnt <= 35));
        apb(1'b0, `ST_CTRL0_OFFSET, 32'h00000000);
        check("sp_run", 0, rdat[0]);
        check("sp_irq", 1, irq);
        for (int c = 0; c < 4; c++) begin
            start(ctl(2'b01, 2'(c), 1'b0, 1'b0, 1'b1, 1'b1), 16'h0000, 8'h00, 1'b1);
            cyc(20);
            cap_lvl <= 1'b1;
            cyc(14);
            apb(1'b0, `ST_FLAGS_OFFSET, 32'h00000000);
            check("cap_rise", cap_r[c], rdat[0]);
            if (c == 0) begin
                apb(1'b0, `ST_CMPA_OFFSET, 32'h00000000);
                a_sv = rdat;
                apb(1'b0, `ST_COUNT_OFFSET, 32'h00000000);
                check("cap_value_ok", 1, 32'(a_sv > 0 && a_sv < rdat));
                check("cap_irq", 1, irq);
            end
            apb(1'b1, `ST_FLAGS_OFFSET, 32'h00000003);
            cap_lvl <= 1'b0;
            cyc(14);
            apb(1'b0, `ST_FLAGS_OFFSET, 32'h00000000);
            check("cap_fall", cap_f[c], rdat[0]);
        end
        start(ctl(2'b01, 2'b11, 1'b0, 1'b0, 1'b0, 1'b0), 16'h0000, 8'h01, 1'b1);
        cyc(700);
        apb(1'b0, `ST_COUNT_OFFSET, 32'h00000000);
        check("cap_wrap", 1, 32'(rdat < 32'h00000100));
        apb(1'b0, `ST_FLAGS_OFFSET, 32'h00000000);
        check("cap_p_flag", 1, rdat[1]);
        check("cap_p_irq", 1, irq);
        report_and_stop();
    end
endmodule
`default_nettype wire
